// *** hw/irq_enable_map.vh ***
// constants for the cpu interrupt enable masks
`ifndef IRQ_ENABLE_MAP_VH
`define IRQ_ENABLE_MAP_VH
`define MASK_WIDTH          16
`define BIT_REALTIME_OS     15
`define BIT_DATA_LOGGING    14
`define BIT_LEVEL_TOP       13
`define BIT_LEVEL_THIRTEEN  12
`define BIT_LEVEL_TWELVE    11
`define BIT_LEVEL_ELEVEN    10
`define BIT_LEVEL_TEN       9
`define BIT_LEVEL_NINE      8
`define BIT_LEVEL_EIGHT     7
`define BIT_LEVEL_SEVEN     6
`define BIT_LEVEL_SIX       5
`define BIT_LEVEL_FIVE      4
`define BIT_LEVEL_FOUR      3
`define BIT_LEVEL_THREE     2
`define BIT_LEVEL_TWO       1
`define BIT_LEVEL_ONE       0
`define IEM_RESET           16'h0000
`define DIEM_RESET          16'h0000
`endif

// *** hw/mask_register.v ***
// one 16-bit enable mask with full write, or-set, and-clear and hardware clear
`include "irq_enable_map.vh"
module mask_register #(
    parameter WIDTH               = `MASK_WIDTH,
    parameter [WIDTH-1:0] RST_VAL = `IEM_RESET
) (
    // clock and reset
    input  wire             clock,
    input  wire             resetn,
    // software access
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             or_en,
    input  wire             and_en,
    input  wire [WIDTH-1:0] op_data,
    // hardware clear
    input  wire [WIDTH-1:0] hw_clear,
    // current value
    output wire [WIDTH-1:0] value
);
    reg  [WIDTH-1:0] mask_ff;
    reg  [WIDTH-1:0] nxt_mask;

    // full write first, then or/and, hardware clear applied last so a
    // serviced line cannot stay enabled by a same-cycle software write
    always @* begin
        nxt_mask = mask_ff;
        if (wr_en) begin
            nxt_mask = wr_data;
        end else if (or_en) begin
            nxt_mask = mask_ff | op_data;
        end else if (and_en) begin
            nxt_mask = mask_ff & op_data;
        end
        nxt_mask = nxt_mask & ~hw_clear;
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= RST_VAL;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    assign value = mask_ff;
endmodule // mask_register

// *** hw/cpu_interrupt_enable_masks.v ***
// cpu interrupt enable masks and request qualification
//
// Functional notes
// - bit 15 of normal mask enables the realtime os interrupt.
// - bit 14 of normal mask enables the data logging interrupt.
// - normal mask bits 13..0 gate levels 14..1, bit n gates level n+1.
// - debug mask matters only while halted in realtime emulation mode.
// - halted in realtime mode, serve only lines enabled in both masks.
// - running in realtime mode, debug mask is ignored completely.
// - debug mask is read/write; 1 enables, 0 disables, reads return state.
// - debug mask resets to all zeros.
// - debug mask uses the same bit layout as the normal mask.
// - normal mask resets to all zeros.
// - acknowledge only enabled, pending lines with global mask clear.
// - servicing or software interrupt clears the enable bit; trap does not.
`include "irq_enable_map.vh"
module cpu_interrupt_enable_masks #(
    parameter LINES = `MASK_WIDTH
) (
    // clock and reset
    input  wire             clock,
    input  wire             resetn,
    // normal enable mask access from the cpu
    input  wire             iem_write,
    input  wire             iem_or,
    input  wire             iem_and,
    input  wire [LINES-1:0] iem_wdata,
    output reg  [LINES-1:0] iem_rdata,
    // debug enable mask access: stack pop writes, stack push reads
    input  wire             diem_pop,
    input  wire [LINES-1:0] diem_pop_data,
    output reg  [LINES-1:0] diem_push_data,
    // pending flags and cpu state
    input  wire [LINES-1:0] interrupt_pending_flags,
    input  wire             global_interrupt_mask,
    input  wire             rt_halted,
    // acknowledge events from the cpu
    input  wire             service_valid,
    input  wire [3:0]       service_line,
    input  wire             service_is_trap,
    // qualified requests
    output reg  [LINES-1:0] request_lines,
    output reg              request_any
);
    wire [LINES-1:0] interrupt_enable_mask;
    wire [LINES-1:0] debug_interrupt_enable_mask;
    wire [LINES-1:0] serviced_clear;
    wire [LINES-1:0] qualified;
    wire [LINES-1:0] onehot;

    // named views of the normal mask fields, one wire per interrupt
    wire             realtime_os_irq_enable;
    wire             data_logging_irq_enable;
    wire             level_fourteen_enable;
    wire             level_thirteen_enable;
    wire             level_twelve_enable;
    wire             level_eleven_enable;
    wire             level_ten_enable;
    wire             level_nine_enable;
    wire             level_eight_enable;
    wire             level_seven_enable;
    wire             level_six_enable;
    wire             level_five_enable;
    wire             level_four_enable;
    wire             level_three_enable;
    wire             level_two_enable;
    wire             level_one_enable;
    // named views of the debug mask fields, same layout
    wire             debug_realtime_os_enable;
    wire             debug_data_logging_enable;
    wire             debug_level_fourteen_enable;
    wire             debug_level_thirteen_enable;
    wire             debug_level_twelve_enable;
    wire             debug_level_eleven_enable;
    wire             debug_level_ten_enable;
    wire             debug_level_nine_enable;
    wire             debug_level_eight_enable;
    wire             debug_level_seven_enable;
    wire             debug_level_six_enable;
    wire             debug_level_five_enable;
    wire             debug_level_four_enable;
    wire             debug_level_three_enable;
    wire             debug_level_two_enable;
    wire             debug_level_one_enable;
    // both masks rebuilt from their views, msb first
    wire [15:0]      normal_gate;
    wire [15:0]      debug_gate;

    // normal mask fields: os and logging on top, levels 14..1 below
    assign realtime_os_irq_enable  = interrupt_enable_mask[`BIT_REALTIME_OS];
    assign data_logging_irq_enable = interrupt_enable_mask[`BIT_DATA_LOGGING];
    assign level_fourteen_enable   = interrupt_enable_mask[`BIT_LEVEL_TOP];
    assign level_thirteen_enable   = interrupt_enable_mask[`BIT_LEVEL_THIRTEEN];
    assign level_twelve_enable     = interrupt_enable_mask[`BIT_LEVEL_TWELVE];
    assign level_eleven_enable     = interrupt_enable_mask[`BIT_LEVEL_ELEVEN];
    assign level_ten_enable        = interrupt_enable_mask[`BIT_LEVEL_TEN];
    assign level_nine_enable       = interrupt_enable_mask[`BIT_LEVEL_NINE];
    assign level_eight_enable      = interrupt_enable_mask[`BIT_LEVEL_EIGHT];
    assign level_seven_enable      = interrupt_enable_mask[`BIT_LEVEL_SEVEN];
    assign level_six_enable        = interrupt_enable_mask[`BIT_LEVEL_SIX];
    assign level_five_enable       = interrupt_enable_mask[`BIT_LEVEL_FIVE];
    assign level_four_enable       = interrupt_enable_mask[`BIT_LEVEL_FOUR];
    assign level_three_enable      = interrupt_enable_mask[`BIT_LEVEL_THREE];
    assign level_two_enable        = interrupt_enable_mask[`BIT_LEVEL_TWO];
    assign level_one_enable        = interrupt_enable_mask[`BIT_LEVEL_ONE];

    // debug mask fields share the layout bit for bit
    assign debug_realtime_os_enable    = debug_interrupt_enable_mask[`BIT_REALTIME_OS];
    assign debug_data_logging_enable   = debug_interrupt_enable_mask[`BIT_DATA_LOGGING];
    assign debug_level_fourteen_enable = debug_interrupt_enable_mask[`BIT_LEVEL_TOP];
    assign debug_level_thirteen_enable = debug_interrupt_enable_mask[`BIT_LEVEL_THIRTEEN];
    assign debug_level_twelve_enable   = debug_interrupt_enable_mask[`BIT_LEVEL_TWELVE];
    assign debug_level_eleven_enable   = debug_interrupt_enable_mask[`BIT_LEVEL_ELEVEN];
    assign debug_level_ten_enable      = debug_interrupt_enable_mask[`BIT_LEVEL_TEN];
    assign debug_level_nine_enable     = debug_interrupt_enable_mask[`BIT_LEVEL_NINE];
    assign debug_level_eight_enable    = debug_interrupt_enable_mask[`BIT_LEVEL_EIGHT];
    assign debug_level_seven_enable    = debug_interrupt_enable_mask[`BIT_LEVEL_SEVEN];
    assign debug_level_six_enable      = debug_interrupt_enable_mask[`BIT_LEVEL_SIX];
    assign debug_level_five_enable     = debug_interrupt_enable_mask[`BIT_LEVEL_FIVE];
    assign debug_level_four_enable     = debug_interrupt_enable_mask[`BIT_LEVEL_FOUR];
    assign debug_level_three_enable    = debug_interrupt_enable_mask[`BIT_LEVEL_THREE];
    assign debug_level_two_enable      = debug_interrupt_enable_mask[`BIT_LEVEL_TWO];
    assign debug_level_one_enable      = debug_interrupt_enable_mask[`BIT_LEVEL_ONE];

    // gate vectors in register order, so line n means mask bit n;
    // the layout is fixed at sixteen lines whatever LINES says
    assign normal_gate = {realtime_os_irq_enable, data_logging_irq_enable,
                          level_fourteen_enable, level_thirteen_enable,
                          level_twelve_enable, level_eleven_enable, level_ten_enable,
                          level_nine_enable, level_eight_enable, level_seven_enable,
                          level_six_enable, level_five_enable, level_four_enable,
                          level_three_enable, level_two_enable, level_one_enable};
    assign debug_gate  = {debug_realtime_os_enable, debug_data_logging_enable,
                          debug_level_fourteen_enable, debug_level_thirteen_enable,
                          debug_level_twelve_enable, debug_level_eleven_enable,
                          debug_level_ten_enable, debug_level_nine_enable,
                          debug_level_eight_enable, debug_level_seven_enable,
                          debug_level_six_enable, debug_level_five_enable,
                          debug_level_four_enable, debug_level_three_enable,
                          debug_level_two_enable, debug_level_one_enable};

    // hardware service and software interrupt clear their enable bit,
    // a trap leaves it alone and the service routine must clear it;
    // the clear wins over a software write of the same bit in one cycle
    assign onehot         = {{(LINES-1){1'b0}}, 1'b1} << service_line;
    assign serviced_clear = (service_valid && !service_is_trap) ? onehot
                                                                : {LINES{1'b0}};

    // normal enable mask, zero at reset
    mask_register #(
        .WIDTH   (LINES),
        .RST_VAL (`IEM_RESET)
    ) u_iem (
        .clock    (clock),
        .resetn   (resetn),
        .wr_en    (iem_write),
        .wr_data  (iem_wdata),
        .or_en    (iem_or),
        .and_en   (iem_and),
        .op_data  (iem_wdata),
        .hw_clear (serviced_clear),
        .value    (interrupt_enable_mask)
    );

    // debug enable mask, same layout, written only by a stack pop;
    // the choice of time-critical lines is software's alone, so no
    // hardware clear reaches it and a service leaves it untouched
    mask_register #(
        .WIDTH   (LINES),
        .RST_VAL (`DIEM_RESET)
    ) u_diem (
        .clock    (clock),
        .resetn   (resetn),
        .wr_en    (diem_pop),
        .wr_data  (diem_pop_data),
        .or_en    (1'b0),
        .and_en   (1'b0),
        .op_data  ({LINES{1'b0}}),
        .hw_clear ({LINES{1'b0}}),
        .value    (debug_interrupt_enable_mask)
    );

    // per-line qualification; the debug gate is held open while running,
    // so a stale debug mask can never starve a running cpu
    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1) begin : g_qualify
            wire debug_open;
            assign debug_open   = rt_halted ? debug_gate[g] : 1'b1;
            assign qualified[g] = interrupt_pending_flags[g] & normal_gate[g] &
                                  debug_open;
        end
    endgenerate

    // read copies lag the masks by one edge; a push samples the copy,
    // which keeps the mask flops off the cpu's read path
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            iem_rdata      <= `IEM_RESET;
            diem_push_data <= `DIEM_RESET;
        end else begin
            iem_rdata      <= interrupt_enable_mask;
            diem_push_data <= debug_interrupt_enable_mask;
        end
    end

    // requests: the lines ignore the global mask so the cpu can still
    // see what waits; only the summary waits on the global mask bit
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            request_lines  <= {LINES{1'b0}};
            request_any    <= 1'b0;
        end else begin
            request_lines  <= qualified;
            request_any    <= (|qualified) && !global_interrupt_mask;
        end
    end
endmodule // cpu_interrupt_enable_masks

// *** tb/irq_mask_assertions.sv ***
// checker for the interrupt enable masks
module irq_mask_chk #(parameter LINES = 16) (
    input logic clock, resetn, iem_write, iem_or, iem_and, diem_pop, request_any,
    input logic global_interrupt_mask, rt_halted, service_valid, service_is_trap,
    input logic [3:0] service_line,
    input logic [LINES-1:0] iem_wdata, iem_rdata, diem_pop_data, diem_push_data,
    input logic [LINES-1:0] interrupt_pending_flags, request_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // read copies lag the masks by one edge, as do the requests
    property p_qual; request_lines == ($past(interrupt_pending_flags) & iem_rdata
        & ($past(rt_halted) ? diem_push_data : {LINES{1'b1}})); endproperty
    a_qual: assert property (p_qual) else $error("request lines off");
    property p_any; request_any == (|request_lines && !$past(global_interrupt_mask)); endproperty
    a_any: assert property (p_any) else $error("request any off");
    property p_wr; iem_write && !service_valid |-> ##2 iem_rdata == $past(iem_wdata, 2); endproperty
    a_wr: assert property (p_wr) else $error("mask write lost");
    property p_or; iem_or && !iem_write && !service_valid |-> ##2
        (iem_rdata & $past(iem_wdata, 2)) == $past(iem_wdata, 2); endproperty
    a_or: assert property (p_or) else $error("mask set lost");
    property p_and; iem_and && !iem_write && !iem_or |-> ##2 !(iem_rdata & ~$past(iem_wdata, 2));
    endproperty
    a_and: assert property (p_and) else $error("mask clear lost");
    property p_pop; diem_pop |-> ##2 diem_push_data == $past(diem_pop_data, 2); endproperty
    a_pop: assert property (p_pop) else $error("debug mask write lost");
    property p_svc; service_valid && !service_is_trap |-> ##2 !iem_rdata[$past(service_line, 2)];
    endproperty
    a_svc: assert property (p_svc) else $error("serviced bit kept");
    property p_trap; service_valid && service_is_trap && !(iem_write | iem_or | iem_and)
        |=> ##1 $stable(iem_rdata); endproperty
    a_trap: assert property (p_trap) else $error("trap changed mask");
endmodule // irq_mask_chk
bind cpu_interrupt_enable_masks irq_mask_chk #(.LINES(LINES)) chk (.*);

// *** tb/cpu_ack_model.sv ***
// cpu acknowledge model: services the lowest requesting line
module cpu_ack_model (
    input  logic        clock, resetn, ack_en, trap, request_any,
    input  logic [15:0] request_lines,
    output logic        service_valid, service_is_trap,
    output logic [3:0]  service_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] lowest;
    // lowest requesting line, found before the edge so the line is set once
    always @* begin
        lowest = 4'h0;
        for (int i = 15; i >= 0; i--) if (request_lines[i]) lowest = i[3:0];
    end
    // a gap after each pulse; a repeat on a stale request only clears again
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            service_valid <= 1'b0;
            service_is_trap <= 1'b0;
            service_line <= 4'h0;
        end else begin
            service_valid <= ack_en & request_any & !service_valid;
            service_is_trap <= trap;
            service_line <= lowest;
        end
    end
endmodule // cpu_ack_model

// *** tb/tb.sv ***
// testbench for the cpu interrupt enable masks
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, resetn = 1'b0, iem_write = 1'b0, iem_or = 1'b0, iem_and = 1'b0;
    logic diem_pop = 1'b0, global_interrupt_mask = 1'b0, rt_halted = 1'b0;
    logic ack_en = 1'b0, trap = 1'b0, service_valid, service_is_trap, request_any;
    logic [3:0]  service_line;
    logic [15:0] iem_wdata = 16'h0000, diem_pop_data = 16'h0000, iem_rdata, diem_push_data;
    logic [15:0] interrupt_pending_flags = 16'h0000, request_lines;
    int n_mismatch = 0, n_compared = 0;
    cpu_interrupt_enable_masks uut (.*);
    cpu_ack_model cpu (.*);
    initial begin
        forever #10 clock = ~clock;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one-cycle strobe, then two edges so the registered outputs settle
    task drv(input logic [3:0] s, input logic [15:0] d, p, input logic [3:0] c);
        @(posedge clock);
        {diem_pop, iem_and, iem_or, iem_write} <= s;
        {iem_wdata, diem_pop_data, interrupt_pending_flags} <= {d, d, p};
        {ack_en, trap, rt_halted, global_interrupt_mask} <= c;
        @(posedge clock);
        {diem_pop, iem_and, iem_or, iem_write} <= 4'h0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task t_levels;
        for (int i = 0; i < 16; i++) begin
            drv(4'h1, 16'h0001 << i, 16'hFFFF, 4'h0);
            chk(request_lines, 16'h0001 << i);
            chk({15'h0000, request_any}, 16'h0001);
        end
    endtask
    task t_halt;
        drv(4'h8, 16'h8001, 16'hFFFF, 4'h0);
        drv(4'h2, 16'h4003, 16'hFFFF, 4'h2);
        chk(request_lines, 16'h8001);
        chk(diem_push_data, 16'h8001);
        drv(4'h0, 16'h0000, 16'hFFFF, 4'h1);
        chk(request_lines, 16'hC003);
        chk({15'h0000, request_any}, 16'h0000);
    endtask
    task t_svc;
        int k;
        drv(4'h4, 16'h0006, 16'h0006, 4'h8);
        for (k = 0; k < 20 && iem_rdata !== 16'h0000; k++) begin
            @(posedge clock);
            #1;
        end
        chk(iem_rdata, 16'h0000);
        if (k == 20) end_of_test;
        drv(4'h1, 16'h0004, 16'h0004, 4'hC);
        drv(4'h0, 16'h0000, 16'h0004, 4'hC);
        chk(iem_rdata, 16'h0004);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        drv(4'h0, 16'h0000, 16'h0000, 4'h0);
        chk(iem_rdata, 16'h0000);
        chk(diem_push_data, 16'h0000);
        t_levels;
        t_halt;
        t_svc;
        end_of_test;
    end
endmodule // tb
